// ==== dacpo_capture.sv ====
// Capture side model that registers both code buses on the rising edge.
`timescale 1ns/1ps
module dacpo_capture (
    // Clock from the capture side.
    input wire logic clk,
    // Code buses and their driver enable.
    input wire logic [dacpo_pkg::CODE_W-1:0] code_a,
    input wire logic [dacpo_pkg::CODE_W-1:0] code_b,
    input wire logic oe,
    // Captured pair and its validity.
    output dacpo_pkg::dacpo_pair_t word_q,
    output logic valid_q
);
    // Last pin levels, so a released bus shows their inverse and toggles every cycle.
    logic [dacpo_pkg::CODE_W-1:0] last_a_q = '0;
    logic [dacpo_pkg::CODE_W-1:0] last_b_q = '0;
    // Cycles since the drivers came on.
    int cnt_q = 0;
    // Wire levels as the capture pins see them.
    wire [dacpo_pkg::CODE_W-1:0] pin_a = oe ? code_a : ~last_a_q;
    wire [dacpo_pkg::CODE_W-1:0] pin_b = oe ? code_b : ~last_b_q;

    // Register the pins each rising edge and trust them only once the pipeline refilled.
    always_ff @(posedge clk) begin
        word_q <= {pin_b, pin_a};
        last_a_q <= pin_a;
        last_b_q <= pin_b;
        cnt_q <= oe ? cnt_q + 1 : 0;
        valid_q <= oe && (cnt_q >= dacpo_pkg::LATENCY);
    end
endmodule

// ==== dacpo_pkg.sv ====
// Shared constants and types for the dual channel converter output port.
package dacpo_pkg;
    // Width of one channel code and the position of its top bit.
    localparam int CODE_W = 10;
    localparam int CODE_MSB = 9;
    // Pipeline depth from the sampling edge to the output edge, in clock cycles.
    localparam int LATENCY = 5;
    // Width of the register bus address.
    localparam int ADDR_W = 8;
    // Byte addresses of the registers.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // Bit positions inside the control register.
    localparam int CTRL_TWOS_BIT = 0;
    localparam int CTRL_OE_N_BIT = 1;
    localparam int CTRL_STANDBY_BIT = 2;
    localparam int CTRL_SHUTDOWN_BIT = 3;
    // Position of the channel B code inside the status register.
    localparam int STATUS_B_LSB = 16;
    // Reset value of the control register: offset binary, drivers off, running.
    localparam logic [3:0] CTRL_RESET = 4'h2;
    // Bus response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control settings as software writes them.
    typedef struct packed {
        logic full_shutdown;
        logic standby;
        logic output_enable_n;
        logic twos_complement;
    } dacpo_ctrl_t;

    // One sample pair, both channels taken on the same edge.
    typedef struct packed {
        logic [CODE_W-1:0] channel_b;
        logic [CODE_W-1:0] channel_a;
    } dacpo_pair_t;
endpackage

// ==== dacpo_top.sv ====
// Dual channel sampling pipeline with parallel code outputs and a register port.
//
// What this block does
// - Both channels sampled together every rising edge while conversion runs.
// - Outputs update to be valid next edge.
// - Code appears exactly five cycles after sampling.
// - Each channel has its own ten-bit bus.
// - Format low gives offset binary, high two's complement.
// - Standby disables both channels, bias stays.
// - Shutdown stops conversion while asserted.
// - Shutdown with enable low holds last outputs.
// - Enable deasserted turns all data drivers off.
// - Bit nine is the top bit.
`timescale 1ns/1ps
module dacpo_top (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Quantised samples from the two converter front ends, offset binary.
    input wire logic [dacpo_pkg::CODE_W-1:0] CHANNEL_A_SAMPLE,
    input wire logic [dacpo_pkg::CODE_W-1:0] CHANNEL_B_SAMPLE,
    // Parallel code outputs with their driver enables.
    output logic [dacpo_pkg::CODE_W-1:0] CHANNEL_A_CODE,
    output logic CHANNEL_A_CODE_OE,
    output logic [dacpo_pkg::CODE_W-1:0] CHANNEL_B_CODE,
    output logic CHANNEL_B_CODE_OE,
    // Reference bias state and converter activity, for the analog side.
    output logic REF_BIAS_ON,
    output logic CONVERTERS_ON,
    // AXI4-Lite write address channel.
    input wire logic [dacpo_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data channel.
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response channel.
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address channel.
    input wire logic [dacpo_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data channel.
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // Control register and its next value.
    dacpo_pkg::dacpo_ctrl_t ctrl_q;
    dacpo_pkg::dacpo_ctrl_t ctrl_d;
    // Sample pipeline, one stage per cycle of latency before the output stage.
    dacpo_pkg::dacpo_pair_t pipe_q [0:dacpo_pkg::LATENCY-1];
    // Output code stage and driver enable.
    dacpo_pkg::dacpo_pair_t code_q;
    dacpo_pkg::dacpo_pair_t code_d;
    logic drive_q;
    logic bias_q;
    logic conv_on_q;
    // Write channel capture flags and held payload.
    logic aw_got_q;
    logic w_got_q;
    logic [dacpo_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Read channel state.
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Conversion runs only while neither power-save state is selected.
    wire logic run_w = !ctrl_q.standby && !ctrl_q.full_shutdown;
    // Hold the outputs in shutdown and while the pipeline is frozen in standby.
    wire logic out_load_w = run_w;
    // Selected output format.
    wire logic twos_w = ctrl_q.twos_complement;
    // Newest pair taken from both front ends on the same edge.
    wire dacpo_pkg::dacpo_pair_t sample_w = {CHANNEL_B_SAMPLE, CHANNEL_A_SAMPLE};
    // Last pipeline stage, the code that goes out on the next edge.
    wire dacpo_pkg::dacpo_pair_t last_w = pipe_q[dacpo_pkg::LATENCY-1];

    // Format conversion: two's complement flips only the top bit of each code.
    always_comb begin
        code_d = last_w;
        code_d.channel_a[dacpo_pkg::CODE_MSB] ^= twos_w;
        code_d.channel_b[dacpo_pkg::CODE_MSB] ^= twos_w;
    end

    // Write decode: the write completes once address and data are both held.
    wire logic wr_fire_w = aw_got_q && w_got_q && !bvalid_q;
    wire logic wr_ctrl_w = wr_fire_w && (awaddr_q == dacpo_pkg::CTRL_OFFSET);
    wire logic wr_status_w = wr_fire_w && (awaddr_q == dacpo_pkg::STATUS_OFFSET);
    wire logic wr_bad_w = wr_fire_w && !wr_ctrl_w && !wr_status_w;
    // Handshakes on each channel.
    wire logic aw_hs_w = S_AXI_AWVALID && S_AXI_AWREADY;
    wire logic w_hs_w = S_AXI_WVALID && S_AXI_WREADY;
    wire logic ar_hs_w = S_AXI_ARVALID && S_AXI_ARREADY;
    // Read decode.
    wire logic rd_ctrl_w = (S_AXI_ARADDR == dacpo_pkg::CTRL_OFFSET);
    wire logic rd_status_w = (S_AXI_ARADDR == dacpo_pkg::STATUS_OFFSET);
    // Status word: the codes currently standing on both output buses.
    wire logic [31:0] status_w = {6'h00, code_q.channel_b, 6'h00, code_q.channel_a};
    // Control word read back in the low bits.
    wire logic [31:0] ctrl_rd_w = {28'h000_0000, ctrl_q};
    // Read data selection.
    wire logic [31:0] rd_data_w = rd_ctrl_w ? ctrl_rd_w : (rd_status_w ? status_w : 32'h0000_0000);
    wire logic [1:0] rd_resp_w = (rd_ctrl_w || rd_status_w) ? dacpo_pkg::RESP_OKAY
                                                           : dacpo_pkg::RESP_SLVERR;

    // Next control value: only byte lane 0 carries the control bits.
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl_w && wstrb_q[0]) begin
            ctrl_d = dacpo_pkg::dacpo_ctrl_t'(wdata_q[3:0]);
        end
    end

    // Control register.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ctrl_q <= dacpo_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Sample pipeline: every stage advances together while conversion runs.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            for (int i = 0; i < dacpo_pkg::LATENCY; i++) begin
                pipe_q[i] <= '0;
            end
        end else if (run_w) begin
            pipe_q[0] <= sample_w;
            for (int i = 1; i < dacpo_pkg::LATENCY; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
        end
    end

    // Output stage, loaded on the fifth edge after sampling and held when stopped.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            code_q <= '0;
        end else if (out_load_w) begin
            code_q <= code_d;
        end
    end

    // Driver enable and power state outputs.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            drive_q <= 1'b0;
            bias_q <= 1'b0;
            conv_on_q <= 1'b0;
        end else begin
            drive_q <= !ctrl_q.output_enable_n;
            bias_q <= !ctrl_q.full_shutdown;
            conv_on_q <= run_w;
        end
    end

    // Write address and data are taken in either order and held until the response.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs_w) begin
                aw_got_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end else if (wr_fire_w) begin
                aw_got_q <= 1'b0;
            end
            if (w_hs_w) begin
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end else if (wr_fire_w) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // Write response: OKAY for mapped words, SLVERR elsewhere; status is read only.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            bvalid_q <= 1'b0;
            bresp_q <= dacpo_pkg::RESP_OKAY;
        end else if (wr_fire_w) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_bad_w ? dacpo_pkg::RESP_SLVERR : dacpo_pkg::RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read response: one read at a time, data captured when the address is taken.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= dacpo_pkg::RESP_OKAY;
        end else if (ar_hs_w) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_data_w;
            rresp_q <= rd_resp_w;
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // Ready flags, registered; each falls once its item is held.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_got_q && !aw_hs_w && !bvalid_q;
            S_AXI_WREADY <= !w_got_q && !w_hs_w && !bvalid_q;
            S_AXI_ARREADY <= !rvalid_q && !ar_hs_w;
        end
    end

    // Ports driven straight from flip-flops.
    assign CHANNEL_A_CODE = code_q.channel_a;
    assign CHANNEL_B_CODE = code_q.channel_b;
    assign CHANNEL_A_CODE_OE = drive_q;
    assign CHANNEL_B_CODE_OE = drive_q;
    assign REF_BIAS_ON = bias_q;
    assign CONVERTERS_ON = conv_on_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    // Checks run on the system clock and pause during reset.
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    // Six running edges with a steady format fill the pipeline end to end.
    sequence s_run_six;
        (run_w && $stable(twos_w))[*6];
    endsequence

    // Mask that the output stage applies: only the top bit, set in two's complement.
    wire logic [dacpo_pkg::CODE_W-1:0] msb_mask_w = {twos_w, {dacpo_pkg::CODE_MSB{1'b0}}};

    AST_LATENCY_A: assert property (
        s_run_six |=> CHANNEL_A_CODE == ($past(CHANNEL_A_SAMPLE, 6) ^ $past(msb_mask_w)))
        else $error("Channel A code did not follow its sample by five cycles.");
    AST_LATENCY_B: assert property (
        s_run_six |=> CHANNEL_B_CODE == ($past(CHANNEL_B_SAMPLE, 6) ^ $past(msb_mask_w)))
        else $error("Channel B code did not follow its sample by five cycles.");
    AST_OFFSET_BINARY: assert property (
        (run_w && !twos_w) |=> CHANNEL_A_CODE == $past(last_w.channel_a))
        else $error("Offset binary code was altered on its way out.");
    AST_TWOS_MSB: assert property (
        (run_w && twos_w) |=> CHANNEL_B_CODE[dacpo_pkg::CODE_MSB]
            != $past(last_w.channel_b[dacpo_pkg::CODE_MSB]))
        else $error("Two's complement code did not invert the top bit.");
    AST_SHUTDOWN_HOLD: assert property (
        ctrl_q.full_shutdown |=> $stable(CHANNEL_A_CODE) && $stable(CHANNEL_B_CODE))
        else $error("Outputs changed during shutdown.");
    AST_SHUTDOWN_STOP: assert property (
        ctrl_q.full_shutdown |=> $stable(pipe_q[0]) && !CONVERTERS_ON)
        else $error("Conversion continued during shutdown.");
    AST_STANDBY_BIAS: assert property (
        (ctrl_q.standby && !ctrl_q.full_shutdown) |=> REF_BIAS_ON && !CONVERTERS_ON)
        else $error("Standby did not keep bias on and converters off.");
    AST_DRIVERS_OFF: assert property (
        ctrl_q.output_enable_n |=> !CHANNEL_A_CODE_OE && !CHANNEL_B_CODE_OE)
        else $error("Data drivers stayed on with output enable deasserted.");
    AST_UPDATE_NEXT: assert property (
        run_w |=> code_q == $past(code_d))
        else $error("Output stage missed its update edge.");

endmodule

// ==== testbench.sv ====
// Self-checking bench for the dual channel code output port.
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 0;
    logic reset = 1;
    logic [9:0] samp_a = '0, samp_b = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire [9:0] code_a, code_b;
    wire oe_a, oe_b, bias_on, conv_on, awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    dacpo_pkg::dacpo_pair_t cap_word, last_exp, e;
    logic cap_valid;
    // Control of the sample driver.
    logic streaming = 0, noise = 0, twos_exp = 0;
    int cyc = 0, errors = 0, n_compared = 0, seed = 61885, k = 0;
    int q_due[$];
    dacpo_pkg::dacpo_pair_t q_word[$];

    // Free running system clock.
    always #5 clk_sys = ~clk_sys;

    dacpo_top dut (.CLK_SYS(clk_sys), .RESET(reset), .CHANNEL_A_SAMPLE(samp_a),
        .CHANNEL_B_SAMPLE(samp_b), .CHANNEL_A_CODE(code_a), .CHANNEL_A_CODE_OE(oe_a),
        .CHANNEL_B_CODE(code_b), .CHANNEL_B_CODE_OE(oe_b), .REF_BIAS_ON(bias_on),
        .CONVERTERS_ON(conv_on), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    dacpo_capture capture (.clk(clk_sys), .code_a(code_a), .code_b(code_b), .oe(oe_a),
        .word_q(cap_word), .valid_q(cap_valid));

    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic results();
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One bus write; address and data are released each at its own handshake.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        check(bresp, r);
        bready <= 0;
    endtask

    // One bus read with its expected data and response.
    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        check(rdata, d);
        check(rresp, r);
        rready <= 0;
    endtask

    // Edge counter; the value read at a falling edge names the last rising edge.
    always @(posedge clk_sys) cyc <= cyc + 1;

    // Sample driver: boundary codes and random ones, each noted with its capture cycle while streaming.
    always @(posedge clk_sys) begin
        if (streaming || noise) begin
            e.channel_a = (k % 8 == 0) ? 10'h000 : (k % 8 == 1) ? 10'h3FF : 10'($random(seed));
            e.channel_b = (k % 8 == 2) ? 10'h200 : 10'($random(seed));
            k++;
            samp_a <= e.channel_a;
            samp_b <= e.channel_b;
            if (streaming) begin
                e.channel_a[dacpo_pkg::CODE_MSB] ^= twos_exp;
                e.channel_b[dacpo_pkg::CODE_MSB] ^= twos_exp;
                q_due.push_back(cyc + 8);
                q_word.push_back(e);
                last_exp = e;
            end
        end
    end

    // Monitor: a word is due one edge after it reaches the pins.
    always @(negedge clk_sys) begin
        if (q_due.size() > 0 && q_due[0] == cyc) begin
            check(cap_word, q_word[0]);
            check(cap_valid, 1'b1);
            void'(q_due.pop_front());
            void'(q_word.pop_front());
        end
    end

    // Watchdog against a hung handshake.
    initial begin
        #200000;
        errors++;
        results();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 0;
        axi_read(dacpo_pkg::CTRL_OFFSET, 32'h0000_0002, dacpo_pkg::RESP_OKAY);
        check(oe_a, 1'b0);
        axi_write(dacpo_pkg::CTRL_OFFSET, 32'h0000_0000, dacpo_pkg::RESP_OKAY);
        foreach (q_due[i]) check(1'b0, 1'b1);
        repeat (3) @(posedge clk_sys);
        for (int f = 0; f < 2; f++) begin
            twos_exp <= f[0];
            streaming <= 1;
            repeat (40) @(posedge clk_sys);
            streaming <= 0;
            repeat (12) @(posedge clk_sys);
            if (f == 0) axi_write(dacpo_pkg::CTRL_OFFSET, 32'h0000_0001, dacpo_pkg::RESP_OKAY);
            repeat (8) @(posedge clk_sys);
        end
        // Shutdown with drivers on, then standby: codes hold while samples change.
        for (int m = 0; m < 2; m++) begin
            axi_write(dacpo_pkg::CTRL_OFFSET, m ? 32'h0000_0005 : 32'h0000_0009,
                dacpo_pkg::RESP_OKAY);
            noise <= 1;
            repeat (10) @(posedge clk_sys);
            noise <= 0;
            @(negedge clk_sys);
            check({code_b, code_a}, last_exp);
            check(conv_on, 1'b0);
            check(bias_on, m[0]);
            axi_read(dacpo_pkg::STATUS_OFFSET, {6'h00, last_exp.channel_b, 6'h00,
                last_exp.channel_a}, dacpo_pkg::RESP_OKAY);
        end
        axi_write(dacpo_pkg::CTRL_OFFSET, 32'h0000_0003, dacpo_pkg::RESP_OKAY);
        repeat (3) @(negedge clk_sys);
        check({oe_a, oe_b, cap_valid}, 3'b000);
        // Status is read only: a write there is ignored and answered OKAY.
        axi_write(dacpo_pkg::STATUS_OFFSET, 32'h0000_0000, dacpo_pkg::RESP_OKAY);
        axi_write(8'h20, 32'h0000_0000, dacpo_pkg::RESP_SLVERR);
        axi_read(8'h10, 32'h0000_0000, dacpo_pkg::RESP_SLVERR);
        // A write with byte lane 0 switched off leaves the control bits alone.
        wstrb <= 4'h0;
        axi_write(dacpo_pkg::CTRL_OFFSET, 32'h0000_0000, dacpo_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        axi_read(dacpo_pkg::CTRL_OFFSET, 32'h0000_0003, dacpo_pkg::RESP_OKAY);
        // Every noted word must have been seen at the pins.
        check(q_due.size(), 0);
        results();
    end
endmodule
